// File: spfs_core_model.sv
// Processor core model: control writes, store and load instructions.
// Assumes the sequencer samples on the rising edge; drives on the falling.
`timescale 1ns/1ps
module spfs_core_model (
  // Clock and status
  input wire ref_clk,
  input wire eeprom_write_busy_flag,
  input wire [7:0] program_control_reg,
  // Instruction side
  output reg ctl_wr,
  output reg [7:0] ctl_wdata,
  output reg store_instr,
  output reg load_instr,
  output reg [15:0] pointer,
  output reg [15:0] reg_pair
);
  integer k;
  integer n_to;
  initial begin
    n_to = 0;
    ctl_wr = 1'b0;
    ctl_wdata = 8'h00;
    store_instr = 1'b0;
    load_instr = 1'b0;
    pointer = 16'h0000;
    reg_pair = 16'h0000;
  end
  // Gap counts edges from control write to instruction; raw skips polling
  task cmd(input [7:0] code, input [15:0] ptr, input [15:0] data,
    input integer gap, input integer kind, input raw);
    begin
      k = 0;
      while (!raw && k < 200 && (program_control_reg[0] !== 1'b0 ||
        eeprom_write_busy_flag !== 1'b0)) begin
        @(negedge ref_clk);
        k = k + 1;
      end
      // A poll that runs out is reported to the bench as a failure
      if (k >= 200)
        n_to = n_to + 1;
      @(negedge ref_clk);
      pointer = ptr;
      reg_pair = data;
      ctl_wdata = code;
      ctl_wr = 1'b1;
      @(negedge ref_clk);
      ctl_wr = 1'b0;
      repeat (gap - 1) @(negedge ref_clk);
      store_instr = (kind == 1);
      load_instr = (kind == 2);
      @(negedge ref_clk);
      store_instr = 1'b0;
      load_instr = 1'b0;
      // Operands are not held after the instruction
      pointer = ~ptr;
      reg_pair = ~data;
    end
  endtask
endmodule

// File: spfs_page_buf.v
// Temporary page buffer of the sequencer: one word per slot.
// Assumes single clock, synchronous active-high reset; clear wipes valids.
`timescale 1ns/1ps
`include "spfs_regs.vh"

module spfs_page_buf #(
  parameter WORD_BITS = 6,
  parameter DATA_W = 16
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Control
  input wire clear,
  input wire wr_en,
  input wire [WORD_BITS-1:0] wr_slot,
  input wire [DATA_W-1:0] wr_data,
  // Read side for the page write engine
  input wire [WORD_BITS-1:0] rd_slot,
  output reg [DATA_W-1:0] rd_data,
  output reg rd_valid
);

  localparam DEPTH = 1 << WORD_BITS;

  reg [DATA_W-1:0] mem [0:DEPTH-1];
  reg [DEPTH-1:0] valid_r;

  // Erased slot reads as all ones, as erased flash would
  always @(posedge ref_clk) begin
    if (wr_en)
      mem[wr_slot] <= wr_data;
    rd_data <= valid_r[rd_slot] ? mem[rd_slot] : {DATA_W{1'b1}};
  end

  always @(posedge ref_clk) begin
    if (sys_rst) begin
      valid_r <= {DEPTH{1'b0}};
      rd_valid <= 1'b0;
    end else begin
      rd_valid <= valid_r[rd_slot];
      if (clear)
        valid_r <= {DEPTH{1'b0}};
      else if (wr_en)
        valid_r[wr_slot] <= 1'b1;
    end
  end

endmodule

// File: spfs_prog_timer.v
// Programming duration timer: counts a flash operation to completion.
// Not reset by sys_rst so a started write always finishes.
`timescale 1ns/1ps
`include "spfs_regs.vh"

module spfs_prog_timer #(
  parameter PROG_CYCLES = `SPFS_PROG_CYCLES,
  parameter CNT_W = 20
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Control
  input wire start,
  output wire busy,
  output wire done
);

  reg [CNT_W-1:0] cnt_r;
  reg run_r;
  reg init_r;

  assign busy = run_r & init_r;
  assign done = busy && (cnt_r == {CNT_W{1'b0}});

  // The running operation ignores sys_rst; only power-up init clears it
  always @(posedge ref_clk) begin
    if (!init_r) begin
      if (sys_rst) begin
        init_r <= 1'b1;
        run_r <= 1'b0;
        cnt_r <= {CNT_W{1'b0}};
      end
    end else if (start && !run_r) begin
      run_r <= 1'b1;
      cnt_r <= PROG_CYCLES[CNT_W-1:0] - {{(CNT_W-1){1'b0}}, 1'b1};
    end else if (run_r) begin
      if (cnt_r == {CNT_W{1'b0}})
        run_r <= 1'b0;
      else
        cnt_r <= cnt_r - {{(CNT_W-1){1'b0}}, 1'b1};
    end
  end

  initial init_r = 1'b0;

endmodule

// File: spfs_regs.vh
// Constants for the self-program flash sequencer: control bit positions,
// command codes, pointer layout, fuse defaults and timing counts.
// Included by every design file of the sequencer; definitions only.
`ifndef SPFS_REGS_VH
`define SPFS_REGS_VH

// Bit positions in the program control register
`define SPFS_BIT_ENABLE 0
`define SPFS_BIT_ERASE 1
`define SPFS_BIT_WRITE 2
`define SPFS_BIT_PROT_SET 3
`define SPFS_BIT_REENABLE 4
`define SPFS_BIT_BUSY 6
`define SPFS_BIT_IRQ_EN 7

// Lower five-bit command codes
`define SPFS_CMD_LOAD 5'h01
`define SPFS_CMD_ERASE 5'h03
`define SPFS_CMD_WRITE 5'h05
`define SPFS_CMD_PROT 5'h09
`define SPFS_CMD_REEN 5'h11

// Pointer layout
`define SPFS_WORD_LSB 1
`define SPFS_PAGE_LSB 7
`define SPFS_PTR_LOW_FUSE 16'h0000
`define SPFS_PTR_PROT 16'h0001
`define SPFS_PTR_EXT_FUSE 16'h0002
`define SPFS_PTR_HIGH_FUSE 16'h0003

// Readback byte defaults (one = unprogrammed)
`define SPFS_FUSE_LOW_RST 8'hff
`define SPFS_FUSE_HIGH_RST 8'hff
`define SPFS_FUSE_EXT_RST 8'hff
`define SPFS_PROT_RST 6'h3f
`define SPFS_EXT_MASK 8'h1e

// Arming windows in cycles
`define SPFS_STORE_WIN 3'h4
`define SPFS_LOAD_WIN 3'h3

// Programming time in microseconds and derived cycles at 250 MHz
`define SPFS_PROG_TIME_US 3700
`define SPFS_CLK_MHZ 250
`define SPFS_PROG_CYCLES (`SPFS_PROG_TIME_US * `SPFS_CLK_MHZ)

`endif

// File: spfs_seq_assertions.sv
// Port checker for the flash sequencer, bound to its top module.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/1ps
module spfs_seq_assertions #(
  parameter PAGE_BITS = 7,
  parameter NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Instructions
  input wire store_instr,
  input wire load_instr,
  input wire load_data_valid,
  // Status
  input wire [7:0] program_control_reg,
  input wire flash_write_start,
  input wire [PAGE_BITS-1:0] flash_page,
  input wire cpu_halt,
  input wire section_read_block,
  input wire irq_req
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (sys_rst);

  AST_LOAD_ANSWER: assert property (load_instr |=> load_data_valid)
    else $error("load gave no answer");
  AST_LOAD_CAUSE: assert property (load_data_valid |-> $past(load_instr))
    else $error("load answer without load");
  AST_IRQ_LEVEL: assert property (irq_req ==
    (program_control_reg[7] && !program_control_reg[0]))
    else $error("irq level wrong");
  AST_BLOCK_FLAG: assert property (section_read_block ==
    program_control_reg[6])
    else $error("read block differs from busy flag");
  // Plain load arming must lapse by the fourth cycle
  AST_ARM_WINDOW: assert property ($rose(program_control_reg[0]) &&
    program_control_reg[4:1] == 4'h0 |-> ##[1:4] !program_control_reg[0])
    else $error("store window did not lapse");
  AST_WRITE_START: assert property (flash_write_start |->
    $past(store_instr) && $past(program_control_reg[2]))
    else $error("write start without armed store");
  AST_PROT_NO_HALT: assert property (program_control_reg[3] |-> !cpu_halt)
    else $error("halt during protection set");
  AST_HALT_PAGE: assert property ($rose(cpu_halt) |->
    flash_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
    else $error("halt for a read-while-write page");
  AST_BUSY_ON_WRITE: assert property (flash_write_start &&
    flash_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE |-> ##[0:1] section_read_block)
    else $error("busy flag not set by write");

  AST_COV_BUSY: cover property ($rose(section_read_block));
  AST_COV_HALT: cover property ($rose(cpu_halt));
  AST_COV_IRQ: cover property ($rose(irq_req));
endmodule

bind spfs_sequencer spfs_seq_assertions #(
  .PAGE_BITS(PAGE_BITS), .NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE(NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE)
) chk_u (
  .ref_clk(ref_clk), .sys_rst(sys_rst), .store_instr(store_instr),
  .load_instr(load_instr), .load_data_valid(load_data_valid),
  .program_control_reg(program_control_reg),
  .flash_write_start(flash_write_start), .flash_page(flash_page),
  .cpu_halt(cpu_halt), .section_read_block(section_read_block),
  .irq_req(irq_req)
);

// File: spfs_sequencer.v
// Self-program flash sequencer: control register, store/load windows,
// page buffer loading, page write and erase, protection set, readback.
// Assumes the core pulses ctl_wr, store_instr and load_instr for one
// cycle each, with pointer and register pair valid in that cycle.
`timescale 1ns/1ps
`include "spfs_regs.vh"

module spfs_sequencer #(
  parameter WORD_BITS = 6,
  parameter PAGE_BITS = 7,
  parameter NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE = 7'h70,
  parameter PROG_CYCLES = `SPFS_PROG_CYCLES,
  parameter CNT_W = 20
) (
  // Clock and reset
  input wire ref_clk,
  input wire sys_rst,
  // Control register access from the core
  input wire ctl_wr,
  input wire [7:0] ctl_wdata,
  output wire [7:0] program_control_reg,
  // Instructions from the core
  input wire store_instr,
  input wire load_instr,
  input wire [15:0] pointer,
  input wire [15:0] reg_pair,
  output reg [7:0] load_data,
  output reg load_data_valid,
  // Program memory read data for ordinary loads
  input wire [15:0] flash_word,
  // EEPROM status
  input wire eeprom_write_busy_flag,
  // Flash array interface
  output reg flash_write_start,
  output reg flash_erase_start,
  output reg [PAGE_BITS-1:0] flash_page,
  input wire [WORD_BITS-1:0] buf_rd_slot,
  output wire [15:0] buf_rd_data,
  output wire buf_rd_valid,
  // Core status
  output wire cpu_halt,
  output wire section_read_block,
  output wire irq_req,
  // Fuse and protection storage
  output reg [5:0] prot_byte,
  output wire [7:0] fuse_low_byte,
  output wire [7:0] fuse_high_byte,
  output wire [7:0] fuse_extended_byte
);

  reg program_enable_bit_r;
  reg protection_set_bit_r;
  reg write_bit_r;
  reg erase_bit_r;
  reg reenable_bit_r;
  reg irq_en_r;
  reg section_busy_flag_r;
  reg [2:0] win_cnt_r;
  reg prog_active_r;
  reg prog_no_read_while_write_section_r;
  reg loading_r;
  reg [4:0] cmd_nxt;
  reg rst_hold_r;

  wire busy;
  wire done;
  wire cmd_ok;
  wire store_go;
  wire load_armed;
  wire buf_clear;
  wire reen_wr;
  wire [PAGE_BITS-1:0] ptr_page;
  wire [WORD_BITS-1:0] ptr_word;

  assign ptr_page = pointer[`SPFS_PAGE_LSB +: PAGE_BITS];
  assign ptr_word = pointer[`SPFS_WORD_LSB +: WORD_BITS];

  assign fuse_low_byte = `SPFS_FUSE_LOW_RST;
  assign fuse_high_byte = `SPFS_FUSE_HIGH_RST;
  assign fuse_extended_byte = `SPFS_FUSE_EXT_RST;

  always @* begin
    cmd_nxt = ctl_wdata[4:0];
  end

  // Only the five defined patterns take effect
  assign cmd_ok = (cmd_nxt == `SPFS_CMD_LOAD) ||
                  (cmd_nxt == `SPFS_CMD_ERASE) ||
                  (cmd_nxt == `SPFS_CMD_WRITE) ||
                  (cmd_nxt == `SPFS_CMD_PROT) ||
                  (cmd_nxt == `SPFS_CMD_REEN);

  // Writing the re-enable pattern aborts a load in progress at once
  assign reen_wr = ctl_wr && (cmd_nxt == `SPFS_CMD_REEN) &&
                   !eeprom_write_busy_flag && !prog_active_r;

  // The window counts down from four; zero means the store is disarmed
  assign store_go = store_instr && program_enable_bit_r && !prog_active_r &&
                    (win_cnt_r != 3'h0) && !eeprom_write_busy_flag;
  // Readback takes only the first three cycles of that window
  assign load_armed = program_enable_bit_r && protection_set_bit_r &&
                      !prog_active_r && (win_cnt_r > 3'h1) &&
                      !eeprom_write_busy_flag;

  assign program_control_reg = {irq_en_r, section_busy_flag_r, 1'b0,
                                reenable_bit_r, protection_set_bit_r,
                                write_bit_r, erase_bit_r,
                                program_enable_bit_r};

  assign irq_req = irq_en_r && !program_enable_bit_r;
  assign section_read_block = section_busy_flag_r;
  assign cpu_halt = prog_active_r && prog_no_read_while_write_section_r;

  // Buffer clear: after page write, on re-enable, on EEPROM write, and
  // after a reset that had to wait for programming to finish
  assign buf_clear = (done && write_bit_r) ||
                     (done && rst_hold_r) ||
                     reen_wr || (store_go && reenable_bit_r) ||
                     (loading_r && eeprom_write_busy_flag);

  spfs_page_buf #(
    .WORD_BITS(WORD_BITS),
    .DATA_W(16)
  ) u_buf (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst && !busy),
    .clear(buf_clear),
    .wr_en(store_go && !write_bit_r && !erase_bit_r &&
           !protection_set_bit_r && !reenable_bit_r),
    .wr_slot(ptr_word),
    .wr_data(reg_pair),
    .rd_slot(buf_rd_slot),
    .rd_data(buf_rd_data),
    .rd_valid(buf_rd_valid)
  );

  spfs_prog_timer #(
    .PROG_CYCLES(PROG_CYCLES),
    .CNT_W(CNT_W)
  ) u_timer (
    .ref_clk(ref_clk),
    .sys_rst(sys_rst),
    .start(store_go && (write_bit_r || erase_bit_r ||
                        protection_set_bit_r)),
    .busy(busy),
    .done(done)
  );

  // A reset during programming must not wipe the page being written;
  // the buffer is cleared once the operation has finished instead
  always @(posedge ref_clk) begin
    if (!busy)
      rst_hold_r <= 1'b0;
    else if (sys_rst)
      rst_hold_r <= 1'b1;
  end

  // Control bits and arming window; an active operation survives reset
  always @(posedge ref_clk) begin
    if (sys_rst && !busy) begin
      program_enable_bit_r <= 1'b0;
      protection_set_bit_r <= 1'b0;
      write_bit_r <= 1'b0;
      erase_bit_r <= 1'b0;
      reenable_bit_r <= 1'b0;
      irq_en_r <= 1'b0;
      section_busy_flag_r <= 1'b0;
      win_cnt_r <= 3'h0;
      prog_active_r <= 1'b0;
      prog_no_read_while_write_section_r <= 1'b0;
      loading_r <= 1'b0;
      flash_page <= {PAGE_BITS{1'b0}};
    end else if (prog_active_r) begin
      if (done) begin
        prog_active_r <= 1'b0;
        program_enable_bit_r <= 1'b0;
        write_bit_r <= 1'b0;
        erase_bit_r <= 1'b0;
        protection_set_bit_r <= 1'b0;
        prog_no_read_while_write_section_r <= 1'b0;
      end
      if (ctl_wr)
        irq_en_r <= ctl_wdata[`SPFS_BIT_IRQ_EN];
    end else begin
      if (ctl_wr)
        irq_en_r <= ctl_wdata[`SPFS_BIT_IRQ_EN];
      if (ctl_wr && cmd_ok && !eeprom_write_busy_flag) begin
        program_enable_bit_r <= 1'b1;
        erase_bit_r <= ctl_wdata[`SPFS_BIT_ERASE];
        write_bit_r <= ctl_wdata[`SPFS_BIT_WRITE];
        protection_set_bit_r <= ctl_wdata[`SPFS_BIT_PROT_SET];
        reenable_bit_r <= ctl_wdata[`SPFS_BIT_REENABLE];
        win_cnt_r <= `SPFS_STORE_WIN;
      end else if (store_go) begin
        win_cnt_r <= 3'h0;
        reenable_bit_r <= 1'b0;
        if (write_bit_r || erase_bit_r) begin
          prog_active_r <= 1'b1;
          flash_page <= ptr_page;
          prog_no_read_while_write_section_r <= (ptr_page >= NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
          section_busy_flag_r <= (ptr_page < NO_READ_WHILE_WRITE_SECTION_FIRST_PAGE);
          loading_r <= 1'b0;
        end else if (protection_set_bit_r) begin
          prog_active_r <= 1'b1;
          prog_no_read_while_write_section_r <= 1'b0;
        end else begin
          program_enable_bit_r <= 1'b0;
          if (reenable_bit_r) begin
            section_busy_flag_r <= 1'b0;
            loading_r <= 1'b0;
          end else begin
            section_busy_flag_r <= 1'b0;
            loading_r <= 1'b1;
          end
        end
      end else if (load_instr && load_armed) begin
        program_enable_bit_r <= 1'b0;
        protection_set_bit_r <= 1'b0;
        win_cnt_r <= 3'h0;
      end else if (win_cnt_r != 3'h0) begin
        win_cnt_r <= win_cnt_r - 3'h1;
        if (win_cnt_r == 3'h1) begin
          program_enable_bit_r <= 1'b0;
          protection_set_bit_r <= 1'b0;
          write_bit_r <= 1'b0;
          erase_bit_r <= 1'b0;
          reenable_bit_r <= 1'b0;
        end
      end
      if (loading_r && eeprom_write_busy_flag)
        loading_r <= 1'b0;
    end
  end

  // Flash array write and erase strobes
  always @(posedge ref_clk) begin
    if (sys_rst && !busy) begin
      flash_write_start <= 1'b0;
      flash_erase_start <= 1'b0;
    end else begin
      flash_write_start <= store_go && write_bit_r;
      flash_erase_start <= store_go && erase_bit_r;
    end
  end

  // Protection bits are nonvolatile; only programming clears them
  always @(posedge ref_clk) begin
    if (store_go && protection_set_bit_r && !write_bit_r && !erase_bit_r)
      prot_byte[5:2] <= prot_byte[5:2] & reg_pair[5:2];
  end

  initial prot_byte = `SPFS_PROT_RST;

  // Load instruction answer, one cycle after the instruction
  always @(posedge ref_clk) begin
    if (sys_rst) begin
      load_data <= 8'h00;
      load_data_valid <= 1'b0;
    end else begin
      load_data_valid <= load_instr;
      if (load_instr) begin
        if (load_armed) begin
          case (pointer)
            `SPFS_PTR_PROT: load_data <= {2'b11, prot_byte};
            `SPFS_PTR_LOW_FUSE: load_data <= fuse_low_byte;
            `SPFS_PTR_HIGH_FUSE: load_data <= fuse_high_byte;
            `SPFS_PTR_EXT_FUSE:
              load_data <= fuse_extended_byte | ~`SPFS_EXT_MASK;
            default: load_data <= 8'hff;
          endcase
        end else begin
          load_data <= pointer[0] ? flash_word[15:8] : flash_word[7:0];
        end
      end
    end
  end

endmodule

// File: spfs_sequencer_bench.sv
// Bench for the flash sequencer: core model drives, bench judges ports.
// Assumes 250 MHz and a programming time shortened to 20 cycles.
`timescale 1ns/1ps
module spfs_sequencer_bench;
  reg ref_clk = 1'b0;
  reg sys_rst = 1'b1;
  reg eeprom_write_busy_flag = 1'b0;
  reg [5:0] buf_rd_slot = 6'h00;
  reg [15:0] flash_word = 16'ha55a;
  wire ctl_wr, store_instr, load_instr, load_data_valid, buf_rd_valid;
  wire flash_write_start, flash_erase_start, cpu_halt;
  wire section_read_block, irq_req;
  wire [7:0] ctl_wdata, program_control_reg, load_data;
  wire [7:0] fuse_low_byte, fuse_high_byte, fuse_extended_byte;
  wire [15:0] pointer, reg_pair, buf_rd_data;
  wire [6:0] flash_page;
  wire [5:0] prot_byte;
  integer n_mismatch = 0;
  integer n_checks = 0;
  integer i;
  reg [7:0] rb_exp;
  reg [7:0] rb_msk;

  always #2 ref_clk = ~ref_clk;

  spfs_sequencer #(.PROG_CYCLES(20)) dut_u (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .program_control_reg(program_control_reg),
    .store_instr(store_instr), .load_instr(load_instr),
    .pointer(pointer), .reg_pair(reg_pair), .load_data(load_data),
    .load_data_valid(load_data_valid), .flash_word(flash_word),
    .eeprom_write_busy_flag(eeprom_write_busy_flag),
    .flash_write_start(flash_write_start),
    .flash_erase_start(flash_erase_start), .flash_page(flash_page),
    .buf_rd_slot(buf_rd_slot), .buf_rd_data(buf_rd_data),
    .buf_rd_valid(buf_rd_valid), .cpu_halt(cpu_halt),
    .section_read_block(section_read_block), .irq_req(irq_req),
    .prot_byte(prot_byte), .fuse_low_byte(fuse_low_byte),
    .fuse_high_byte(fuse_high_byte),
    .fuse_extended_byte(fuse_extended_byte)
  );

  spfs_core_model core_u (
    .ref_clk(ref_clk), .eeprom_write_busy_flag(eeprom_write_busy_flag),
    .program_control_reg(program_control_reg), .ctl_wr(ctl_wr),
    .ctl_wdata(ctl_wdata), .store_instr(store_instr),
    .load_instr(load_instr), .pointer(pointer), .reg_pair(reg_pair)
  );

  task chk(input [8*8-1:0] what, input [15:0] exp, input [15:0] got);
    begin
      n_checks = n_checks + 1;
      if (got !== exp) begin
        n_mismatch = n_mismatch + 1;
        $display("Error %0s expected %h seen %h", what, exp, got);
      end
    end
  endtask

  task finish_test;
    begin
      $display("checks %0d mismatches %0d", n_checks, n_mismatch);
      if (n_mismatch == 0 && n_checks > 0) begin
        $display("bench passed");
      end else begin
        $display("bench failed");
      end
      $finish;
    end
  endtask

  // Slot read has one cycle of latency
  task rd(input [5:0] s);
    begin
      buf_rd_slot = s;
      @(negedge ref_clk);
    end
  endtask

  task t_reset;
    begin
      chk("ctl", 16'h0000, {8'h00, program_control_reg});
      chk("prot", 16'h003f, {10'h000, prot_byte});
      chk("fuses", 16'hffff, {fuse_high_byte, fuse_low_byte});
      chk("extfuse", 16'h00ff, {8'h00, fuse_extended_byte});
    end
  endtask

  task t_buffer;
    begin
      core_u.cmd(8'h01, 16'h000a, 16'h1234, 2, 1, 1'b0);
      chk("enable", 16'h0000, {15'h0, program_control_reg[0]});
      rd(6'h05);
      chk("slot", 16'h1234, buf_rd_data);
      core_u.cmd(8'h11, 16'h0000, 16'h0000, 2, 1, 1'b0);
      rd(6'h05);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
    end
  endtask

  task t_misc;
    begin
      core_u.cmd(8'h01, 16'h0006, 16'hbeef, 6, 1, 1'b0);
      rd(6'h03);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
      core_u.cmd(8'h07, 16'h0000, 16'h0000, 1, 0, 1'b0);
      chk("ctl", 16'h0000, {8'h00, program_control_reg});
      core_u.cmd(8'h09, 16'h0001, 16'h0000, 5, 2, 1'b0);
      chk("load", 16'h00a5, {8'h00, load_data});
      core_u.cmd(8'h00, 16'h0000, 16'h0000, 1, 2, 1'b0);
      chk("load", 16'h005a, {8'h00, load_data});
      chk("ldvalid", 16'h0001, {15'h0, load_data_valid});
    end
  endtask

  task t_eeprom;
    begin
      core_u.cmd(8'h01, 16'h0004, 16'h0bad, 2, 1, 1'b0);
      eeprom_write_busy_flag = 1'b1;
      repeat (2) @(negedge ref_clk);
      rd(6'h02);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
      core_u.cmd(8'h09, 16'h0003, 16'h0000, 1, 2, 1'b1);
      chk("load", 16'h00a5, {8'h00, load_data});
      eeprom_write_busy_flag = 1'b0;
    end
  endtask

  task t_write;
    begin
      core_u.cmd(8'h03, 16'h0180, 16'h0000, 2, 1, 1'b0);
      chk("erase", 16'h0001, {15'h0, flash_erase_start});
      core_u.cmd(8'h11, 16'h0000, 16'h0000, 2, 1, 1'b0);
      core_u.cmd(8'h01, 16'h0000, 16'h4321, 2, 1, 1'b0);
      core_u.cmd(8'h85, 16'h0180, 16'hffff, 2, 1, 1'b0);
      chk("wstart", 16'h0001, {15'h0, flash_write_start});
      chk("page", 16'h0003, {9'h000, flash_page});
      chk("block", 16'h0001, {15'h0, section_read_block});
      chk("halt", 16'h0000, {15'h0, cpu_halt});
      chk("irq", 16'h0000, {15'h0, irq_req});
      repeat (25) @(negedge ref_clk);
      chk("irq", 16'h0001, {15'h0, irq_req});
      chk("block", 16'h0001, {15'h0, section_read_block});
      rd(6'h00);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
      core_u.cmd(8'h11, 16'h0000, 16'h0000, 2, 1, 1'b0);
      chk("block", 16'h0000, {15'h0, section_read_block});
    end
  endtask

  task t_no_read_while_write_section;
    begin
      core_u.cmd(8'h01, 16'h0002, 16'h5a5a, 2, 1, 1'b0);
      core_u.cmd(8'h05, 16'h3800, 16'h0000, 2, 1, 1'b0);
      chk("halt", 16'h0001, {15'h0, cpu_halt});
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      chk("halt", 16'h0001, {15'h0, cpu_halt});
      rd(6'h01);
      chk("valid", 16'h0001, {15'h0, buf_rd_valid});
      repeat (25) @(negedge ref_clk);
      chk("halt", 16'h0000, {15'h0, cpu_halt});
      chk("enable", 16'h0000, {15'h0, program_control_reg[0]});
      rd(6'h01);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
      core_u.cmd(8'h01, 16'h0002, 16'h5a5a, 2, 1, 1'b0);
      sys_rst = 1'b1;
      @(negedge ref_clk);
      sys_rst = 1'b0;
      rd(6'h01);
      chk("valid", 16'h0000, {15'h0, buf_rd_valid});
    end
  endtask

  task t_prot;
    begin
      core_u.cmd(8'h09, 16'h0001, 16'hffd7, 2, 1, 1'b0);
      chk("halt", 16'h0000, {15'h0, cpu_halt});
      repeat (25) @(negedge ref_clk);
      chk("prot", 16'h0017, {10'h000, prot_byte});
      for (i = 0; i < 4; i = i + 1) begin
        rb_msk = (i == 1) ? 8'h3f : (i == 2) ? 8'h1e : 8'hff;
        rb_exp = (i == 1) ? 8'h17 : rb_msk;
        core_u.cmd(8'h09, i[15:0], 16'h0000, 1, 2, 1'b0);
        chk("readbk", {8'h00, rb_exp}, {8'h00, load_data & rb_msk});
        chk("enable", 16'h0000, {15'h0, program_control_reg[0]});
      end
    end
  endtask

  initial begin
    repeat (10) @(negedge ref_clk);
    sys_rst = 1'b0;
    @(negedge ref_clk);
    t_reset;
    t_buffer;
    t_misc;
    t_eeprom;
    t_write;
    t_no_read_while_write_section;
    t_prot;
    chk("polltime", 16'h0000, core_u.n_to[15:0]);
    finish_test;
  end

  // The sequence needs well under a thousand cycles
  initial begin
    #20000;
    n_mismatch = n_mismatch + 1;
    finish_test;
  end
endmodule
